// *** common/gopi_defs.vh ***
// register offsets, field positions and reset values of the gang output / pin interrupt block
`ifndef GOPI_DEFS_VH
`define GOPI_DEFS_VH

// register offsets (byte addresses on the 4-bit register port)
`define GOPI_OFF_GANG_CTRL 4'h0
`define GOPI_OFF_A_STAT_CTRL 4'h1
`define GOPI_OFF_A_IRQ_EN 4'h2
`define GOPI_OFF_A_EDGE_SEL 4'h3
`define GOPI_OFF_B_STAT_CTRL 4'h4
`define GOPI_OFF_B_IRQ_EN 4'h5
`define GOPI_OFF_B_EDGE_SEL 4'h6
`define GOPI_OFF_MASTER_PIN 4'h7
`define GOPI_OFF_PWR_STAT_CTRL 4'h8
`define GOPI_OFF_A_PULL_EN 4'h9
`define GOPI_OFF_B_PULL_EN 4'hA

// gang_output_control fields
`define GOPI_GANG_EN_BIT 0

// pin_irq_status_control fields
`define GOPI_SC_MODE_BIT 0
`define GOPI_SC_IE_BIT 1
`define GOPI_SC_ACK_BIT 2
`define GOPI_SC_FLAG_BIT 3

// master pin (port C bit 0) control fields
`define GOPI_MP_DATA_BIT 0
`define GOPI_MP_DRIVE_BIT 1
`define GOPI_MP_SLEW_BIT 2
`define GOPI_MP_DIR_BIT 3

// power_mgmt_status_control fields
`define GOPI_PM_ACK_BIT 2
`define GOPI_PM_FLAG_BIT 3

// reset values
`define GOPI_RST_BYTE 8'h00
`define GOPI_RST_NIB 4'h0

`endif

// *** design/gopi_top.v ***
// ganged output control, port A/B pin interrupts and stop-mode pin retention
// What this block does
// - gang control register accepts only the first write after reset
// - gang control bit 0 enables the feature, bits 7..1 select pins
// - selected gang pins become outputs using master pin data, drive, slew
// - select 7..4 map to port B 5..2, 3..1 to port C 3..1, enable to C0
// - port C pin 0 is forced to output while gang enable is one
// - gang beats digital peripherals; an enabled analog function beats gang
// - port A/B bits 3..0 are interrupt inputs and wait/stop3 wake sources
// - each interrupt pin has its own enable bit
// - one mode bit per port selects edge only or edge plus level
// - edge select bit clear means falling/low, set means rising/high
// - edges are found by sampling each bus cycle, old vs new value
// - an edge counts only after the enabled pin was seen deasserted
// - valid edge sets the port flag; ack clears it in edge-only mode
// - edge-plus-level: edge or level sets flag; ack clears only if all idle
// - edge-plus-level: flag stays set on ack while any enabled pin asserted
// - enabled pull is pull-up when edge select is 0, pull-down when 1
// - pin latches hold their pre-stop state through partial power-down
// - stop3 keeps all pin state and pins work right after recovery
// - writing one to recovery ack clears the power-down recovery flag
//
// Implementation choices: the plain strobed port and the address map.
`include "gopi_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module gopi_top (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // register port
    input wire [3:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [7:0] rdata_o,
    // interrupt pins, raw from the pads
    input wire [3:0] pta_i,
    input wire [3:0] ptb_i,
    // pull controls of the interrupt pins, index 3..0 port A, 7..4 port B
    input wire [7:0] pull_en_raw_unused_i,
    output reg [7:0] pull_up_o,
    output reg [7:0] pull_dn_o,
    // gang candidate pins: index 0 C0, 3..1 C3..C1, 7..4 B5..B2
    input wire [7:1] norm_oe_i,
    input wire [7:1] norm_do_i,
    input wire [7:1] norm_ds_i,
    input wire [7:1] norm_se_i,
    input wire [7:0] periph_en_i,
    input wire [7:0] periph_oe_i,
    input wire [7:0] periph_do_i,
    input wire [7:0] analog_en_i,
    output reg [7:0] pad_oe_o,
    output reg [7:0] pad_do_o,
    output reg [7:0] pad_ds_o,
    output reg [7:0] pad_se_o,
    // power modes
    input wire stop2_i,
    input wire low_power_i,
    output wire wake_o,
    // interrupt requests
    output wire irq_a_o,
    output wire irq_b_o
);

    // asserted level of a pin under its polarity bit
    function [3:0] pin_active;
        input [3:0] lvl;
        input [3:0] es;
        begin
            pin_active = ~(lvl ^ es);
        end
    endfunction

    // next flag of one port
    function next_flag;
        input flag;
        input mode;
        input ack;
        input [3:0] edge_hit;
        input [3:0] lvl_hit;
        reg set;
        begin
            set = (|edge_hit) | (mode & (|lvl_hit));
            if (set) begin
                next_flag = 1'b1;
            end else if (ack && (!mode || !(|lvl_hit))) begin
                next_flag = 1'b0;
            end else begin
                next_flag = flag;
            end
        end
    endfunction

    // registers
    reg [7:0] gang_ctrl;
    reg gang_locked;
    reg a_mode;
    reg a_ie;
    reg a_flag;
    reg [3:0] a_en;
    reg [3:0] a_es;
    reg [3:0] a_pe;
    reg b_mode;
    reg b_ie;
    reg b_flag;
    reg [3:0] b_en;
    reg [3:0] b_es;
    reg [3:0] b_pe;
    reg [3:0] master;
    reg pd_flag;

    // pin synchronisers and history
    reg [7:0] pin_meta;
    reg [7:0] pin_sync;
    reg [7:0] idle_seen;
    reg stop2_q;

    wire wr_gang = wr_i && (addr_i == `GOPI_OFF_GANG_CTRL);
    wire wr_a_sc = wr_i && (addr_i == `GOPI_OFF_A_STAT_CTRL);
    wire wr_b_sc = wr_i && (addr_i == `GOPI_OFF_B_STAT_CTRL);
    wire wr_pm = wr_i && (addr_i == `GOPI_OFF_PWR_STAT_CTRL);
    wire a_ack = wr_a_sc && wdata_i[`GOPI_SC_ACK_BIT];
    wire b_ack = wr_b_sc && wdata_i[`GOPI_SC_ACK_BIT];

    // pin activity, port A in the low nibble
    wire [3:0] a_act = pin_active(pin_sync[3:0], a_es) & a_en;
    wire [3:0] b_act = pin_active(pin_sync[7:4], b_es) & b_en;
    // an edge is an asserted sample right after a deasserted enabled sample
    wire [3:0] a_edge = a_act & idle_seen[3:0];
    wire [3:0] b_edge = b_act & idle_seen[7:4];

    assign irq_a_o = a_flag & a_ie;
    assign irq_b_o = b_flag & b_ie;
    // wake is the registered request gated by low_power_i, with no clocked stage after the flag, so wait/stop3 exit is prompt
    assign wake_o = low_power_i & (irq_a_o | irq_b_o);

    // pin sampling; the first stage feeds only the second
    always @(posedge clk_i) begin
        if (rst_i) begin
            pin_meta <= `GOPI_RST_BYTE;
            pin_sync <= `GOPI_RST_BYTE;
            idle_seen <= `GOPI_RST_BYTE;
        end else begin
            pin_meta <= {ptb_i, pta_i};
            pin_sync <= pin_meta;
            idle_seen <= {~b_act & b_en, ~a_act & a_en};
        end
    end

    // control and status registers
    always @(posedge clk_i) begin
        if (rst_i) begin
            gang_ctrl <= `GOPI_RST_BYTE;
            gang_locked <= 1'b0;
            a_mode <= 1'b0;
            a_ie <= 1'b0;
            a_flag <= 1'b0;
            a_en <= `GOPI_RST_NIB;
            a_es <= `GOPI_RST_NIB;
            a_pe <= `GOPI_RST_NIB;
            b_mode <= 1'b0;
            b_ie <= 1'b0;
            b_flag <= 1'b0;
            b_en <= `GOPI_RST_NIB;
            b_es <= `GOPI_RST_NIB;
            b_pe <= `GOPI_RST_NIB;
            master <= `GOPI_RST_NIB;
            pd_flag <= 1'b0;
            stop2_q <= 1'b0;
        end else begin
            stop2_q <= stop2_i;
            if (wr_gang && !gang_locked) begin
                gang_ctrl <= wdata_i;
                gang_locked <= 1'b1;
            end
            if (wr_a_sc) begin
                a_mode <= wdata_i[`GOPI_SC_MODE_BIT];
                a_ie <= wdata_i[`GOPI_SC_IE_BIT];
            end
            if (wr_b_sc) begin
                b_mode <= wdata_i[`GOPI_SC_MODE_BIT];
                b_ie <= wdata_i[`GOPI_SC_IE_BIT];
            end
            if (wr_i && addr_i == `GOPI_OFF_A_IRQ_EN) begin
                a_en <= wdata_i[3:0];
            end
            if (wr_i && addr_i == `GOPI_OFF_B_IRQ_EN) begin
                b_en <= wdata_i[3:0];
            end
            if (wr_i && addr_i == `GOPI_OFF_A_EDGE_SEL) begin
                a_es <= wdata_i[3:0];
            end
            if (wr_i && addr_i == `GOPI_OFF_B_EDGE_SEL) begin
                b_es <= wdata_i[3:0];
            end
            if (wr_i && addr_i == `GOPI_OFF_A_PULL_EN) begin
                a_pe <= wdata_i[3:0];
            end
            if (wr_i && addr_i == `GOPI_OFF_B_PULL_EN) begin
                b_pe <= wdata_i[3:0];
            end
            if (wr_i && addr_i == `GOPI_OFF_MASTER_PIN) begin
                master <= wdata_i[3:0];
            end
            a_flag <= next_flag(a_flag, a_mode, a_ack, a_edge, a_act);
            b_flag <= next_flag(b_flag, b_mode, b_ack, b_edge, b_act);
            // leaving partial power-down raises the flag; the set wins over an ack
            if (stop2_q && !stop2_i) begin
                pd_flag <= 1'b1;
            end else if (wr_pm && wdata_i[`GOPI_PM_ACK_BIT]) begin
                pd_flag <= 1'b0;
            end
        end
    end

    // pad steering: analog, then gang, then digital peripheral, then plain port
    reg [7:0] next_oe;
    reg [7:0] next_do;
    reg [7:0] next_ds;
    reg [7:0] next_se;
    reg [7:0] gang_sel;
    integer i;
    always @* begin
        // bit 0 is the master pin itself, selected by the enable alone
        gang_sel = {gang_ctrl[7:1], 1'b1} & {8{gang_ctrl[`GOPI_GANG_EN_BIT]}};
        next_oe = {norm_oe_i, master[`GOPI_MP_DIR_BIT]};
        next_do = {norm_do_i, master[`GOPI_MP_DATA_BIT]};
        next_ds = {norm_ds_i, master[`GOPI_MP_DRIVE_BIT]};
        next_se = {norm_se_i, master[`GOPI_MP_SLEW_BIT]};
        for (i = 0; i < 8; i = i + 1) begin
            if (analog_en_i[i]) begin
                next_oe[i] = 1'b0;
                next_do[i] = 1'b0;
            end else if (gang_sel[i]) begin
                next_oe[i] = 1'b1;
                next_do[i] = master[`GOPI_MP_DATA_BIT];
                next_ds[i] = master[`GOPI_MP_DRIVE_BIT];
                next_se[i] = master[`GOPI_MP_SLEW_BIT];
            end else if (periph_en_i[i]) begin
                next_oe[i] = periph_oe_i[i];
                next_do[i] = periph_do_i[i];
            end
        end
    end

    // pad latches; frozen during partial power-down, stop3 needs no special case
    always @(posedge clk_i) begin
        if (rst_i) begin
            pad_oe_o <= `GOPI_RST_BYTE;
            pad_do_o <= `GOPI_RST_BYTE;
            pad_ds_o <= `GOPI_RST_BYTE;
            pad_se_o <= `GOPI_RST_BYTE;
            pull_up_o <= `GOPI_RST_BYTE;
            pull_dn_o <= `GOPI_RST_BYTE;
        end else if (!stop2_i) begin
            pad_oe_o <= next_oe;
            pad_do_o <= next_do;
            pad_ds_o <= next_ds;
            pad_se_o <= next_se;
            pull_up_o <= {b_pe & ~b_es, a_pe & ~a_es};
            pull_dn_o <= {b_pe & b_es, a_pe & a_es};
        end
    end

    // read data stands for the single cycle after the strobe
    always @(posedge clk_i) begin
        if (rst_i || !rd_i) begin
            rdata_o <= `GOPI_RST_BYTE;
        end else begin
            case (addr_i)
                `GOPI_OFF_GANG_CTRL: rdata_o <= gang_ctrl;
                `GOPI_OFF_A_STAT_CTRL: rdata_o <= {4'h0, a_flag, 1'b0, a_ie, a_mode};
                `GOPI_OFF_A_IRQ_EN: rdata_o <= {4'h0, a_en};
                `GOPI_OFF_A_EDGE_SEL: rdata_o <= {4'h0, a_es};
                `GOPI_OFF_B_STAT_CTRL: rdata_o <= {4'h0, b_flag, 1'b0, b_ie, b_mode};
                `GOPI_OFF_B_IRQ_EN: rdata_o <= {4'h0, b_en};
                `GOPI_OFF_B_EDGE_SEL: rdata_o <= {4'h0, b_es};
                `GOPI_OFF_MASTER_PIN: rdata_o <= {4'h0, master};
                `GOPI_OFF_PWR_STAT_CTRL: rdata_o <= {4'h0, pd_flag, 3'h0};
                `GOPI_OFF_A_PULL_EN: rdata_o <= {4'h0, a_pe};
                `GOPI_OFF_B_PULL_EN: rdata_o <= {4'h0, b_pe};
                default: rdata_o <= `GOPI_RST_BYTE;
            endcase
        end
    end

endmodule // gopi_top

`default_nettype wire

// *** test/gopi_pins.sv ***
// board model of the interrupt pins with the pull devices the block selects
`timescale 1ns/1ps
`default_nettype none
module gopi_pins (
    // clock
    input wire logic clk_i,
    // board drive and pull selection
    input wire logic [7:0] drv_en_i,
    input wire logic [7:0] drv_val_i,
    input wire logic [7:0] pull_up_i,
    input wire logic [7:0] pull_dn_i,
    // pin levels
    output logic [7:0] pin_o
);
    logic [7:0] last = 8'h00;
    always @(posedge clk_i) begin
        last <= pin_o;
    end
    // a floating pin flips each cycle so a stale level never passes for a pulled one
    always_comb begin
        for (int k = 0; k < 8; k++) begin
            if (drv_en_i[k]) begin
                pin_o[k] = drv_val_i[k];
            end else if (pull_up_i[k] || pull_dn_i[k]) begin
                pin_o[k] = pull_up_i[k];
            end else begin
                pin_o[k] = ~last[k];
            end
        end
    end
endmodule // gopi_pins
`default_nettype wire

// *** test/gopi_props.sv ***
// assertion checker for the gang output and pin interrupt block
`timescale 1ns/1ps
`default_nettype none
module gopi_props (
    // clock, reset and register port
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    // pads, power and requests
    input wire logic [7:0] analog_en_i,
    input wire logic [7:0] pad_oe_o,
    input wire logic [7:0] pad_do_o,
    input wire logic [7:0] pad_ds_o,
    input wire logic [7:0] pad_se_o,
    input wire logic stop2_i,
    input wire logic low_power_i,
    input wire logic wake_o,
    input wire logic irq_a_o,
    input wire logic irq_b_o
);
    logic [7:0] gang;
    logic gang_done;
    logic [3:0] mp;
    logic [7:0] m;
    // pins that the gang owns right now; analog use takes a pin back
    assign m = gang & {8{gang[0]}} & ~analog_en_i;
    always @(posedge clk_i) begin
        if (rst_i) begin
            gang <= 8'h00;
            gang_done <= 1'b0;
            mp <= 4'h0;
        end else begin
            if (wr_i && addr_i == 4'h0 && !gang_done) begin
                gang <= wdata_i;
                gang_done <= 1'b1;
            end
            if (wr_i && addr_i == 4'h7) begin
                mp <= wdata_i[3:0];
            end
        end
    end
    default clocking dc @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    chk_gang_once: assert property (rd_i && addr_i == 4'h0 |=> rdata_o == $past(gang))
        else $error("gang control readback wrong");
    chk_master_dir: assert property (!$past(stop2_i) && $past(m[0]) |-> pad_oe_o[0])
        else $error("master pin not driven");
    chk_gang_oe: assert property (!$past(stop2_i) |-> (pad_oe_o & $past(m)) == $past(m))
        else $error("gang pin not driven");
    chk_gang_data: assert property (
        !$past(stop2_i) |-> ((pad_do_o ^ {8{$past(mp[0])}}) & $past(m)) == 8'h00)
        else $error("gang pin data wrong");
    chk_gang_drive: assert property (
        !$past(stop2_i) |-> ((pad_ds_o ^ {8{$past(mp[1])}}) & $past(m)) == 8'h00
        && ((pad_se_o ^ {8{$past(mp[2])}}) & $past(m)) == 8'h00)
        else $error("gang pin drive or slew wrong");
    chk_analog_wins: assert property (
        !$past(stop2_i) |-> (pad_oe_o & $past(analog_en_i)) == 8'h00)
        else $error("analog pin driven");
    chk_wake_src: assert property (wake_o == (low_power_i && (irq_a_o || irq_b_o)))
        else $error("wake wrong");
    chk_mask_a: assert property (wr_i && addr_i == 4'h1 && !wdata_i[1] |=> !irq_a_o)
        else $error("port a request while masked");
    chk_mask_b: assert property (wr_i && addr_i == 4'h4 && !wdata_i[1] |=> !irq_b_o)
        else $error("port b request while masked");
    chk_ppd_clear: assert property (
        wr_i && addr_i == 4'h8 && wdata_i[2] && !stop2_i && !$past(stop2_i)
        ##1 !stop2_i ##1 rd_i && addr_i == 4'h8 && !stop2_i |=> !rdata_o[3])
        else $error("recovery flag not cleared");
    cover property (!irq_a_o ##1 irq_a_o);
    cover property (!irq_b_o ##1 irq_b_o);
    cover property (gang[0] && m[7:1] != 7'h00);
    cover property (wake_o);
endmodule // gopi_props
bind gopi_top gopi_props gopi_props_inst (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .analog_en_i, .pad_oe_o, .pad_do_o, .pad_ds_o, .pad_se_o, .stop2_i,
    .low_power_i, .wake_o, .irq_a_o, .irq_b_o);
`default_nettype wire

// *** test/tb_gopi_top.sv ***
// self-checking bench for the gang output and pin interrupt block
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin num_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_gopi_top;
    logic clk_i = 1'b0, rst_i = 1'b1, wr = 1'b0, rd = 1'b0, stop2 = 1'b0, low_pw = 1'b0, e;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, rdata, oe, dout, ds, se, pu, pd, pins, held, g, m, m7, pe_v, es_v;
    logic [7:0] drv_en = 8'hFF, drv_val = 8'hFF, an = 8'h00, pen = 8'hFF, poe = 8'h00, pdo;
    logic [7:1] noe, ndo, nds, nse;
    logic irq_a, irq_b, wake;
    int num_errors = 0, comparisons = 0, seed, k, i, sc;
    gopi_top gopi_top_inst (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .pta_i(pins[3:0]), .ptb_i(pins[7:4]),
        .pull_en_raw_unused_i(8'h00), .pull_up_o(pu), .pull_dn_o(pd), .norm_oe_i(noe),
        .norm_do_i(ndo), .norm_ds_i(nds), .norm_se_i(nse), .periph_en_i(pen),
        .periph_oe_i(poe), .periph_do_i(pdo), .analog_en_i(an), .pad_oe_o(oe),
        .pad_do_o(dout), .pad_ds_o(ds), .pad_se_o(se), .stop2_i(stop2), .low_power_i(low_pw),
        .wake_o(wake), .irq_a_o(irq_a), .irq_b_o(irq_b));
    gopi_pins gopi_pins_inst (.clk_i(clk_i), .drv_en_i(drv_en), .drv_val_i(drv_val),
        .pull_up_i(pu), .pull_dn_i(pd), .pin_o(pins));
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    function automatic logic [7:0] gang_mask(input logic [7:0] gc, input logic [7:0] a);
        return gc & {8{gc[0]}} & ~a;
    endfunction
    task automatic wr_reg(input int a, input logic [7:0] d);
        @(posedge clk_i);
        wr <= 1'b1;
        addr <= 4'(a);
        wdata <= d;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input int a, input logic [7:0] x);
        @(posedge clk_i);
        rd <= 1'b1;
        addr <= 4'(a);
        @(posedge clk_i);
        rd <= 1'b0;
        @(negedge clk_i);
        `CHK(rdata, x)
    endtask
    task automatic final_report();
        $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic wait_irq(input int p, input logic v);
        int n;
        n = 0;
        // never judge the request in the time step of the edge that launches it
        @(negedge clk_i);
        while ((p ? irq_b : irq_a) !== v && n < 8) begin
            @(negedge clk_i);
            n++;
        end
        `CHK((p ? irq_b : irq_a), v)
        if (n == 8 && (p ? irq_b : irq_a) !== v) begin
            final_report();
        end
    endtask
    initial begin
        seed = $urandom(32'h5cf1);
        {noe, ndo, nds, nse} = 28'($urandom);
        pdo = 8'($urandom);
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int a = 0; a < 16; a++) begin
            rd_chk(a, 8'h00);
        end
        $display("test reset done");
        // peripherals claim every pin, yet the gang must win where it owns one
        g = 8'($urandom) | 8'h01;
        m7 = 8'($urandom) & 8'h07;
        an <= 8'($urandom) & 8'h24;
        wr_reg(7, m7);
        wr_reg(0, g);
        wr_reg(0, ~g);
        rd_chk(0, g);
        m = gang_mask(g, an);
        `CHK(oe & m, m)
        `CHK(dout & m, {8{m7[0]}} & m)
        `CHK(ds & m, {8{m7[1]}} & m)
        `CHK(se & m, {8{m7[2]}} & m)
        `CHK(oe & an, 8'h00)
        $display("test gang done");
        k = $urandom_range(3, 0);
        pe_v = 8'($urandom) | (8'h11 << k);
        es_v = 8'($urandom);
        wr_reg(9, pe_v[3:0]);
        wr_reg(10, pe_v[7:4]);
        wr_reg(3, es_v[3:0]);
        wr_reg(6, es_v[7:4]);
        // pull outputs are registered one edge after the edge-select write lands
        @(posedge clk_i);
        @(negedge clk_i);
        `CHK(pu, pe_v & ~es_v)
        `CHK(pd, pe_v & es_v)
        $display("test pulls done");
        for (int p = 0; p < 2; p++) begin
            sc = 1 + 3 * p;
            i = k + 4 * p;
            e = es_v[i];
            drv_en <= 8'hFF;
            drv_val <= ~es_v;
            wr_reg(sc, 8'h00);
            wr_reg(sc + 1, 8'(1 << k));
            wr_reg(sc, 8'h04);
            wr_reg(sc, 8'h02);
            drv_val[i ^ 1] <= es_v[i ^ 1];
            repeat (6) @(negedge clk_i);
            wait_irq(p, 1'b0);
            drv_val[i] <= e;
            wait_irq(p, 1'b1);
            wr_reg(sc, 8'h06);
            repeat (6) @(negedge clk_i);
            wait_irq(p, 1'b0);
            wr_reg(sc, 8'h07);
            wait_irq(p, 1'b1);
            wr_reg(sc, 8'h07);
            @(negedge clk_i);
            wait_irq(p, 1'b1);
            low_pw <= 1'b1;
            @(negedge clk_i);
            `CHK(wake, 1'b1)
            low_pw <= 1'b0;
            wr_reg(sc, 8'h01);
            wait_irq(p, 1'b0);
            wr_reg(sc, 8'h03);
            wait_irq(p, 1'b1);
            drv_en[i] <= 1'b0;
            repeat (4) @(negedge clk_i);
            wr_reg(sc, 8'h07);
            wait_irq(p, 1'b0);
            wr_reg(sc + 1, 8'h00);
            $display("test port %0d done", p);
        end
        @(negedge clk_i);
        held = dout;
        stop2 <= 1'b1;
        wr_reg(7, ~m7 & 8'h07);
        repeat (3) @(negedge clk_i);
        `CHK(dout, held)
        @(posedge clk_i);
        stop2 <= 1'b0;
        rd_chk(8, 8'h08);
        wr_reg(8, 8'h04);
        rd_chk(8, 8'h00);
        `CHK(dout & m, {8{~m7[0]}} & m)
        $display("test stop done");
        final_report();
    end
endmodule // tb_gopi_top
`default_nettype wire
